// file: hdl/sbf_pkg.sv
// sbf_pkg: shared types, field positions, reset values and timings
// assumes one 250 MHz clock; figures below are plain defaults
package sbf_pkg;
  localparam int ADDR_W = 12; // address pins
  localparam int ROW_W = 11; // row address width
  localparam int COL_W = 8; // column address width
  localparam int NUM_BANKS = 2; // banks chosen by the select bit
  localparam int BANK_BIT = 11; // bank select address bit
  localparam int CLOSE_BIT = 10; // autoclose / all-bank bit
  localparam int BL_LSB = 0; // burst length field, low bit
  localparam int WR_SINGLE_BIT = 9; // single write burst option
  localparam int TMR_W = 8; // wait timer width
  localparam int CLK_MHZ = 250; // clock rate
  localparam logic [ADDR_W-1:0] MODE_RST = 12'h000; // mode after reset
  localparam logic [ROW_W-1:0] REFROW_RST = 11'h000; // refresh row after reset
  localparam logic [2:0] BL_FULL = 3'h7; // full page burst code
  // times in ns, least times rounded up to cycles
  localparam int T_RCD_NS = 20; // activate to column
  localparam int T_RP_NS = 20; // precharge to idle
  localparam int T_DPL_NS = 8; // data-in to precharge
  localparam int T_DAL_NS = 28; // data-in to activate
  localparam int T_RC_NS = 68; // refresh cycle
  localparam logic [TMR_W-1:0] RCD_CYC = TMR_W'((T_RCD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] RP_CYC = TMR_W'((T_RP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] DPL_CYC = TMR_W'((T_DPL_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] DAL_CYC = TMR_W'((T_DAL_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] RC_CYC = TMR_W'((T_RC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] MRD_CYC = 8'h02; // mode load delay, in cycles
  // command and address pins, taken at the rising edge
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [ADDR_W-1:0] addr;
  } sbf_pins_t;
  typedef enum logic [3:0] {
    SBF_DESELECT, SBF_NOP, SBF_BURST_STOP, SBF_READ, SBF_WRITE,
    SBF_ACTIVATE, SBF_PRECHARGE, SBF_REFRESH, SBF_MODE_LOAD
  } sbf_cmd_t;
  typedef enum logic [3:0] {
    SBF_IDLE, SBF_ACTIVATING, SBF_ROW_ACTIVE, SBF_READ_ST, SBF_WRITE_ST,
    SBF_READ_AC, SBF_WRITE_AC, SBF_WR_RECOV, SBF_WR_RECOV_AC, SBF_PRECHARGING
  } sbf_bank_st_t;
  typedef enum logic [2:0] {
    SBF_DEV_NORMAL, SBF_DEV_REFRESH, SBF_DEV_MODE_WAIT,
    SBF_DEV_POWER_DOWN, SBF_DEV_SELF_REF, SBF_DEV_SR_RECOV
  } sbf_dev_mode_t;
  // command from the four strobes
  function automatic sbf_cmd_t sbf_decode(input sbf_pins_t p);
    sbf_cmd_t c;
    c = SBF_NOP;
    if (p.cs_n) begin
      c = SBF_DESELECT;
    end else begin
      unique case ({p.ras_n, p.cas_n, p.we_n})
        3'h7: c = SBF_NOP;
        3'h6: c = SBF_BURST_STOP;
        3'h5: c = SBF_READ;
        3'h4: c = SBF_WRITE;
        3'h3: c = SBF_ACTIVATE;
        3'h2: c = SBF_PRECHARGE;
        3'h1: c = SBF_REFRESH;
        3'h0: c = SBF_MODE_LOAD;
      endcase
    end
    return c;
  endfunction
endpackage

// file: hdl/sbf_bank_fsm.sv
// sbf_bank_fsm: per-bank command acceptance and device-wide wait states
// assumes pins are synchronous to mclk and change only after its rising edge
`timescale 1ns/1ns
`default_nettype none
module sbf_bank_fsm
  import sbf_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire sbf_pins_t pins,
  output var sbf_bank_st_t [NUM_BANKS-1:0] bank_state_q,
  output var sbf_dev_mode_t dev_mode_q,
  output var logic [ADDR_W-1:0] mode_reg_q,
  output var logic [ROW_W-1:0] refresh_row_q,
  output var logic [COL_W-1:0] col_addr_q,
  output var logic illegal_q
);
  logic cke_prev_q; // cke at the previous edge
  logic [TMR_W-1:0] dev_tmr_q; // device wait timer
  sbf_cmd_t cmd_raw; // decoded pins
  sbf_cmd_t cmd; // command seen by the banks
  logic all_idle; // both banks idle
  logic cmd_ok; // cke high now and before, device normal
  logic start_ref; // auto refresh begins
  logic start_sref; // self-refresh begins
  logic start_pd; // power-down begins
  logic start_mrs; // mode load begins
  logic dev_ill; // device-level illegal command
  logic [NUM_BANKS-1:0] bank_ill; // per-bank illegal command
  logic [COL_W-1:0] bl_last; // burst length minus one
  logic full_page; // full page burst programmed
  logic nop_like; // deselect, nop or burst stop

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // command decode and gating
  assign cmd_raw = sbf_decode(pins);
  assign cmd_ok = (dev_mode_q == SBF_DEV_NORMAL) && cke_prev_q && pins.cke;
  assign cmd = cmd_ok ? cmd_raw : SBF_NOP;
  assign nop_like = (cmd_raw == SBF_DESELECT) || (cmd_raw == SBF_NOP)
                    || (cmd_raw == SBF_BURST_STOP);
  assign all_idle = (bank_state_q[0] == SBF_IDLE) && (bank_state_q[1] == SBF_IDLE);
  assign full_page = (mode_reg_q[BL_LSB+:3] == BL_FULL);

  // device-level starts, both banks idle and cke high at the last edge
  always_comb begin
    start_ref = 1'b0;
    start_sref = 1'b0;
    start_pd = 1'b0;
    start_mrs = 1'b0;
    if (dev_mode_q == SBF_DEV_NORMAL && all_idle && cke_prev_q) begin
      if (!pins.cke) begin
        start_sref = (cmd_raw == SBF_REFRESH);
        start_pd = (cmd_raw != SBF_REFRESH);
      end else begin
        start_ref = (cmd_raw == SBF_REFRESH);
        start_mrs = (cmd_raw == SBF_MODE_LOAD);
      end
    end
  end

  // illegal commands at device level
  always_comb begin
    dev_ill = 1'b0;
    unique case (dev_mode_q)
      SBF_DEV_REFRESH, SBF_DEV_MODE_WAIT, SBF_DEV_SR_RECOV: begin
        dev_ill = pins.cke && !nop_like;
      end
      SBF_DEV_NORMAL: begin
        // refresh or mode load with a bank open
        dev_ill = cmd_ok && !all_idle
                  && (cmd_raw == SBF_REFRESH || cmd_raw == SBF_MODE_LOAD);
      end
      default: dev_ill = 1'b0; // power-down and self-refresh ignore pins
    endcase
  end

  // burst length from the mode field
  always_comb begin
    unique case (mode_reg_q[BL_LSB+:3])
      3'h1: bl_last = 8'h01;
      3'h2: bl_last = 8'h03;
      3'h3: bl_last = 8'h07;
      3'h7: bl_last = 8'hFF;
      default: bl_last = 8'h00;
    endcase
  end

  // cke history for power-down and self-refresh entry
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cke_prev_q <= 1'b0;
    end else begin
      cke_prev_q <= pins.cke;
    end
  end

  // device mode and its timer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dev_mode_q <= SBF_DEV_NORMAL;
      dev_tmr_q <= '0;
    end else begin
      unique case (dev_mode_q)
        SBF_DEV_NORMAL: begin
          if (start_ref) begin
            dev_mode_q <= SBF_DEV_REFRESH;
            dev_tmr_q <= RC_CYC - 8'h01;
          end else if (start_mrs) begin
            dev_mode_q <= SBF_DEV_MODE_WAIT;
            dev_tmr_q <= MRD_CYC - 8'h01;
          end else if (start_sref) begin
            dev_mode_q <= SBF_DEV_SELF_REF;
          end else if (start_pd) begin
            dev_mode_q <= SBF_DEV_POWER_DOWN;
          end
        end
        SBF_DEV_REFRESH, SBF_DEV_MODE_WAIT, SBF_DEV_SR_RECOV: begin
          // wait out the interval, then idle
          if (dev_tmr_q == '0) begin
            dev_mode_q <= SBF_DEV_NORMAL;
          end else begin
            dev_tmr_q <= dev_tmr_q - 8'h01;
          end
        end
        SBF_DEV_POWER_DOWN: begin
          if (pins.cke) begin
            dev_mode_q <= SBF_DEV_NORMAL;
          end
        end
        SBF_DEV_SELF_REF: begin
          // only cke is looked at here
          if (pins.cke) begin
            dev_mode_q <= SBF_DEV_SR_RECOV;
            dev_tmr_q <= RC_CYC - 8'h01;
          end
        end
        default: dev_mode_q <= SBF_DEV_NORMAL;
      endcase
    end
  end

  // mode register load
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg_q <= MODE_RST;
    end else if (start_mrs) begin
      mode_reg_q <= pins.addr;
    end
  end

  // internal refresh row counter, address pins unused
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      refresh_row_q <= REFROW_RST;
    end else if (start_ref || start_sref) begin
      refresh_row_q <= refresh_row_q + 11'h001;
    end
  end

  // column address of the last column command
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      col_addr_q <= '0;
    end else if (cmd == SBF_READ || cmd == SBF_WRITE) begin
      col_addr_q <= pins.addr[COL_W-1:0];
    end
  end

  // illegal flag, one cycle per offending command
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= dev_ill || (|bank_ill);
    end
  end

  // one state machine per bank
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    sbf_bank_st_t st_d; // next bank state
    logic [TMR_W-1:0] tmr_q; // bank wait timer
    logic [TMR_W-1:0] tmr_d;
    logic [COL_W-1:0] bcnt_q; // beats left in burst
    logic [COL_W-1:0] bcnt_d;
    logic sel; // command addresses this bank
    logic col_rd; // read to this bank
    logic col_wr; // write to this bank
    logic act; // activate to this bank
    logic pre; // precharge reaching this bank
    logic burst_stop_cmd; // burst stop
    logic col_go; // column command accepted
    logic ill; // illegal for this bank
    logic ac_bit; // autoclose requested
    logic done; // last beat of a fixed burst

    assign sel = (pins.addr[BANK_BIT] == 1'(b));
    assign col_rd = (cmd == SBF_READ) && sel;
    assign col_wr = (cmd == SBF_WRITE) && sel;
    assign act = (cmd == SBF_ACTIVATE) && sel;
    assign pre = (cmd == SBF_PRECHARGE) && (sel || pins.addr[CLOSE_BIT]);
    assign burst_stop_cmd = (cmd == SBF_BURST_STOP);
    assign ac_bit = pins.addr[CLOSE_BIT];
    assign done = (bcnt_q == '0) && !full_page;
    assign bank_ill[b] = ill;

    // next state of this bank
    always_comb begin
      st_d = bank_state_q[b];
      tmr_d = (tmr_q != '0) ? tmr_q - 8'h01 : tmr_q;
      bcnt_d = (bcnt_q != '0) ? bcnt_q - 8'h01 : bcnt_q;
      col_go = 1'b0;
      ill = 1'b0;
      unique case (bank_state_q[b])
        SBF_IDLE: begin
          if (act) begin
            st_d = SBF_ACTIVATING;
            tmr_d = RCD_CYC - 8'h01;
          end else if (col_rd || col_wr) begin
            ill = 1'b1;
          end
        end
        SBF_ACTIVATING: begin
          ill = col_rd || col_wr || act || pre;
          if (tmr_q == '0) begin
            st_d = SBF_ROW_ACTIVE;
          end
        end
        SBF_ROW_ACTIVE: begin
          if (col_rd || col_wr) begin
            col_go = 1'b1;
          end else if (pre) begin
            st_d = SBF_PRECHARGING;
            tmr_d = RP_CYC - 8'h01;
          end else if (act) begin
            ill = 1'b1;
          end
        end
        SBF_READ_ST, SBF_WRITE_ST: begin
          if (pre) begin
            st_d = SBF_PRECHARGING;
            tmr_d = RP_CYC - 8'h01;
          end else if (col_rd || col_wr) begin
            col_go = 1'b1;
          end else if (act) begin
            ill = 1'b1;
          end else if (burst_stop_cmd && full_page) begin
            st_d = SBF_ROW_ACTIVE;
          end else if (done && bank_state_q[b] == SBF_READ_ST) begin
            st_d = SBF_ROW_ACTIVE;
          end else if (done) begin
            st_d = SBF_WR_RECOV;
            tmr_d = DPL_CYC - 8'h01;
          end
        end
        SBF_READ_AC, SBF_WRITE_AC: begin
          ill = col_rd || col_wr || act || pre || burst_stop_cmd;
          if (done && bank_state_q[b] == SBF_READ_AC) begin
            st_d = SBF_PRECHARGING;
            tmr_d = RP_CYC - 8'h01;
          end else if (done) begin
            st_d = SBF_WR_RECOV_AC;
            tmr_d = DAL_CYC - 8'h01;
          end
        end
        SBF_WR_RECOV: begin
          if (col_rd || col_wr) begin
            col_go = 1'b1;
          end else if (act || pre) begin
            ill = 1'b1;
          end else if (tmr_q == '0) begin
            st_d = SBF_ROW_ACTIVE;
          end
        end
        SBF_WR_RECOV_AC: begin
          ill = col_rd || col_wr || act || pre;
          if (tmr_q == '0) begin
            st_d = SBF_IDLE;
          end
        end
        SBF_PRECHARGING: begin
          ill = col_rd || col_wr || act; // further precharge is a nop
          if (tmr_q == '0) begin
            st_d = SBF_IDLE;
          end
        end
        default: st_d = SBF_IDLE;
      endcase
      // start or restart a burst on the open row
      if (col_go) begin
        if (col_rd) begin
          st_d = ac_bit ? SBF_READ_AC : SBF_READ_ST;
          bcnt_d = bl_last;
        end else begin
          st_d = ac_bit ? SBF_WRITE_AC : SBF_WRITE_ST;
          bcnt_d = mode_reg_q[WR_SINGLE_BIT] ? 8'h00 : bl_last;
        end
      end
    end

    // bank state, timer and burst counter
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        bank_state_q[b] <= SBF_IDLE;
        tmr_q <= '0;
        bcnt_q <= '0;
      end else begin
        bank_state_q[b] <= st_d;
        tmr_q <= tmr_d;
        bcnt_q <= bcnt_d;
      end
    end

    a_rcd_wait: assert property (
      bank_state_q[b] == SBF_IDLE && act |=>
      (bank_state_q[b] == SBF_ACTIVATING)[*5] ##1 bank_state_q[b] == SBF_ROW_ACTIVE)
      else $error("activation delay wrong");
    a_rp_wait: assert property (
      bank_state_q[b] == SBF_ROW_ACTIVE && pre && !col_rd && !col_wr |=>
      (bank_state_q[b] == SBF_PRECHARGING)[*5] ##1 bank_state_q[b] == SBF_IDLE)
      else $error("precharge time wrong");
    a_dpl_load: assert property (
      bank_state_q[b] == SBF_WRITE_ST ##1 bank_state_q[b] == SBF_WR_RECOV |->
      tmr_q == 8'h01)
      else $error("write recovery length wrong");
    a_dal_idle: assert property (
      $rose(bank_state_q[b] == SBF_WR_RECOV_AC) |-> ##[1:7] bank_state_q[b] == SBF_IDLE)
      else $error("autoclose recovery overran");
    a_autoclose_pre: assert property (
      bank_state_q[b] == SBF_READ_AC && done |=> bank_state_q[b] == SBF_PRECHARGING)
      else $error("autoclose read did not precharge");
    a_wr_restart: assert property (
      bank_state_q[b] == SBF_WR_RECOV && col_wr |=>
      bank_state_q[b] inside {SBF_WRITE_ST, SBF_WRITE_AC})
      else $error("write restart refused");
    a_bank_sel: assert property (
      bank_state_q[b] == SBF_IDLE && cmd == SBF_ACTIVATE && !sel |=>
      bank_state_q[b] == SBF_IDLE)
      else $error("other bank opened");
    a_bst_fixed: assert property (
      bank_state_q[b] == SBF_READ_ST && burst_stop_cmd && !full_page && bcnt_q != '0 |=>
      bank_state_q[b] == SBF_READ_ST)
      else $error("burst stop acted on fixed burst");
    c_read_burst: cover property (
      bank_state_q[b] == SBF_ACTIVATING ##[1:8] bank_state_q[b] == SBF_READ_ST);
    c_write_close: cover property (
      bank_state_q[b] == SBF_WRITE_AC ##[1:300] bank_state_q[b] == SBF_IDLE);
  end

  a_ref_time: assert property (
    dev_mode_q == SBF_DEV_NORMAL ##1 dev_mode_q == SBF_DEV_REFRESH |->
    ##16 dev_mode_q == SBF_DEV_REFRESH ##1 dev_mode_q == SBF_DEV_NORMAL)
    else $error("refresh time wrong");
  a_mrs_capture: assert property (
    start_mrs |=> mode_reg_q == $past(pins.addr) && dev_mode_q == SBF_DEV_MODE_WAIT)
    else $error("mode code not captured");
  a_mrs_illegal: assert property (
    dev_mode_q == SBF_DEV_MODE_WAIT && pins.cke && cmd_raw == SBF_ACTIVATE |=> illegal_q)
    else $error("command in mode wait not flagged");
  a_ref_row: assert property (
    start_ref |=> refresh_row_q == $past(refresh_row_q) + 11'h001)
    else $error("refresh row not advanced");
  a_sref_hold: assert property (
    dev_mode_q == SBF_DEV_SELF_REF && !pins.cke |=>
    dev_mode_q == SBF_DEV_SELF_REF && $stable(bank_state_q) && !illegal_q)
    else $error("self-refresh reacted to pins");
  a_pd_entry: assert property (
    start_pd |=> dev_mode_q == SBF_DEV_POWER_DOWN)
    else $error("power-down not entered");
  c_refresh: cover property (start_ref ##[1:20] dev_mode_q == SBF_DEV_NORMAL);
  c_self_ref: cover property (start_sref ##[1:50] dev_mode_q == SBF_DEV_SR_RECOV);
endmodule // sbf_bank_fsm
`default_nettype wire

// file: test/sbf_ctrl_model.sv
// sbf_ctrl_model: behavioural memory controller that drives the command pins
// assumes its tasks are entered just after a falling edge of mclk
`timescale 1ns/1ns
`default_nettype none
module sbf_ctrl_model
  import sbf_pkg::*;
(
  output var sbf_pins_t pins,
  input wire logic mclk
);
  // time zero: deselect, clock enabled, address low
  initial begin
    pins = {5'h1F, 12'h000};
  end

  // one command for one cycle, then deselect with the address moved on
  task automatic issue(input logic [2:0] rcw, input logic [11:0] a);
    pins.cs_n = 1'b0;
    {pins.ras_n, pins.cas_n, pins.we_n} = rcw;
    pins.addr = a;
    @(negedge mclk);
    pins.cs_n = 1'b1;
    pins.addr = ~a; // a released address keeps no value
  endtask

  // deselect cycles that cover the waits this side owes
  task automatic gap(input int n);
    repeat (n) begin
      @(negedge mclk);
      pins.addr = ~pins.addr;
    end
  endtask

  // clock enable level from the next rising edge on
  task automatic set_cke(input logic v);
    pins.cke = v;
  endtask
endmodule // sbf_ctrl_model
`default_nettype wire

// file: test/sbf_bank_fsm_test.sv
// sbf_bank_fsm_test: self-checking bench for the bank command state machine
// assumes the controller model drives pins; all checks happen at falling edges
`timescale 1ns/1ns
`default_nettype none
module sbf_bank_fsm_test
  import sbf_pkg::*;
;
  localparam logic [2:0] C_BST = 3'h6; // burst stop strobes
  localparam logic [2:0] C_RD = 3'h5; // column read
  localparam logic [2:0] C_WR = 3'h4; // column write
  localparam logic [2:0] C_ACT = 3'h3; // row activate
  localparam logic [2:0] C_PRE = 3'h2; // precharge
  localparam logic [2:0] C_REF = 3'h1; // refresh
  localparam logic [2:0] C_MODE = 3'h0; // mode load
  logic mclk = 1'b0; // 250 MHz clock, low at time zero
  logic arst_n; // reset, active low
  sbf_pins_t pins; // command pins
  sbf_bank_st_t [NUM_BANKS-1:0] bank_st; // per-bank state
  sbf_dev_mode_t dev_mode; // device-wide mode
  logic [ADDR_W-1:0] mode_reg; // captured mode code
  logic [ROW_W-1:0] ref_row; // refresh row counter
  logic [COL_W-1:0] col_addr; // last column address
  logic illegal; // illegal command pulse
  logic [ROW_W-1:0] exp_row; // expected refresh row
  int n_mismatch; // failed comparisons
  int comparisons; // all comparisons

  sbf_bank_fsm u_sbf_bank_fsm (
    .mclk(mclk),
    .arst_n(arst_n),
    .pins(pins),
    .bank_state_q(bank_st),
    .dev_mode_q(dev_mode),
    .mode_reg_q(mode_reg),
    .refresh_row_q(ref_row),
    .col_addr_q(col_addr),
    .illegal_q(illegal)
  );
  sbf_ctrl_model u_sbf_ctrl_model (
    .pins(pins),
    .mclk(mclk)
  );

  // clock
  always #2 mclk = ~mclk;

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic report_and_stop();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one command through the controller model
  task automatic cmd(input logic [2:0] c, input logic [11:0] a);
    u_sbf_ctrl_model.issue(c, a);
  endtask

  // state of bank 0 or 1, or device mode for 2
  function automatic logic [3:0] cur(input int sel);
    return (sel == 2) ? {1'b0, dev_mode} : bank_st[sel];
  endfunction

  // counts cycles a state stands from now on, then compares
  task automatic hold(input int sel, input logic [3:0] st, input int exp);
    int n;
    n = 0;
    while (cur(sel) === st && n < 300) begin
      n++;
      @(negedge mclk);
    end
    check(n, exp);
  endtask

  // bounded wait for a device mode where no cycle count is fixed
  task automatic wait_mode(input sbf_dev_mode_t m);
    int n;
    n = 0;
    while (dev_mode !== m && n < 8) begin
      n++;
      @(negedge mclk);
    end
    check(dev_mode, m);
  endtask

  // mode load with an illegal activate in the wait
  task automatic t_mode_load();
    cmd(C_MODE, 12'h002);
    check(mode_reg, 12'h002);
    check(dev_mode, SBF_DEV_MODE_WAIT);
    cmd(C_ACT, 12'h000);
    check(illegal, 1'b1);
    check(bank_st[0], SBF_IDLE);
    hold(2, SBF_DEV_MODE_WAIT, 1);
  endtask

  // activation delay, burst stop ignored, other bank activated meanwhile
  task automatic t_activate();
    cmd(C_ACT, 12'h000);
    check(bank_st[0], SBF_ACTIVATING);
    cmd(C_BST, 12'h000);
    check(illegal, 1'b0);
    cmd(C_ACT, 12'h800);
    check(bank_st[1], SBF_ACTIVATING);
    check(illegal, 1'b0);
    hold(0, SBF_ACTIVATING, 3);
    check(bank_st[0], SBF_ROW_ACTIVE);
    hold(1, SBF_ACTIVATING, 2);
  endtask

  // autoclose write: burst, recovery, then idle by itself
  task automatic t_write_ac();
    cmd(C_WR, 12'h75A);
    check(col_addr, 8'h5A);
    hold(0, SBF_WRITE_AC, 4);
    check(bank_st[0], SBF_WR_RECOV_AC);
    cmd(C_ACT, 12'h000);
    check(illegal, 1'b1);
    hold(0, SBF_WR_RECOV_AC, 6);
    check(bank_st[0], SBF_IDLE);
  endtask

  // write recovery interrupted by a read, then plain recovery
  task automatic t_wr_recov();
    cmd(C_WR, 12'h810);
    hold(1, SBF_WRITE_ST, 4);
    cmd(C_RD, 12'h820);
    check(illegal, 1'b0);
    hold(1, SBF_READ_ST, 4);
    cmd(C_WR, 12'h830);
    hold(1, SBF_WRITE_ST, 4);
    hold(1, SBF_WR_RECOV, 2);
    check(bank_st[1], SBF_ROW_ACTIVE);
  endtask

  // precharge: repeat is a no-op, read is illegal
  task automatic t_precharge();
    cmd(C_PRE, 12'h800);
    cmd(C_PRE, 12'h800);
    check(illegal, 1'b0);
    cmd(C_RD, 12'h800);
    check(illegal, 1'b1);
    hold(1, SBF_PRECHARGING, 3);
    check(bank_st[1], SBF_IDLE);
  endtask

  // refresh ignores the address; mode load inside it is illegal
  task automatic t_refresh();
    cmd(C_REF, 12'hFFF);
    exp_row = exp_row + 11'h001;
    check(ref_row, exp_row);
    cmd(C_MODE, 12'h0F0);
    check(illegal, 1'b1);
    check(mode_reg, 12'h002);
    hold(2, SBF_DEV_REFRESH, 16);
    check(dev_mode, SBF_DEV_NORMAL);
  endtask

  // power-down and self-refresh ignore the pins
  task automatic t_power();
    u_sbf_ctrl_model.set_cke(1'b0);
    @(negedge mclk);
    check(dev_mode, SBF_DEV_POWER_DOWN);
    cmd(C_ACT, 12'h000);
    check(bank_st[0], SBF_IDLE);
    u_sbf_ctrl_model.set_cke(1'b1);
    wait_mode(SBF_DEV_NORMAL);
    u_sbf_ctrl_model.gap(1);
    u_sbf_ctrl_model.set_cke(1'b0);
    cmd(C_REF, 12'h000);
    exp_row = exp_row + 11'h001;
    check(dev_mode, SBF_DEV_SELF_REF);
    check(ref_row, exp_row);
    cmd(C_MODE, 12'h3FF);
    check(mode_reg, 12'h002);
    check(illegal, 1'b0);
    u_sbf_ctrl_model.set_cke(1'b1);
    wait_mode(SBF_DEV_SR_RECOV);
    hold(2, SBF_DEV_SR_RECOV, 17);
  endtask

  // full page read runs on until a burst stop ends it
  task automatic t_full_page();
    cmd(C_MODE, 12'h007);
    u_sbf_ctrl_model.gap(2);
    cmd(C_ACT, 12'h000);
    hold(0, SBF_ACTIVATING, 5);
    cmd(C_RD, 12'h000);
    u_sbf_ctrl_model.gap(20);
    check(bank_st[0], SBF_READ_ST);
    cmd(C_BST, 12'h000);
    check(bank_st[0], SBF_ROW_ACTIVE);
    cmd(C_PRE, 12'h400);
    hold(0, SBF_PRECHARGING, 5);
  endtask

  // single write option, write restart, fixed burst stop, autoclose read
  task automatic t_single_write();
    cmd(C_MODE, 12'h203);
    check(mode_reg, 12'h203);
    u_sbf_ctrl_model.gap(2);
    cmd(C_ACT, 12'h800);
    hold(1, SBF_ACTIVATING, 5);
    cmd(C_WR, 12'h800);
    hold(1, SBF_WRITE_ST, 1);
    cmd(C_WR, 12'h800);
    check(bank_st[1], SBF_WRITE_ST);
    hold(1, SBF_WRITE_ST, 1);
    hold(1, SBF_WR_RECOV, 2);
    cmd(C_RD, 12'h800);
    cmd(C_BST, 12'h000);
    check(bank_st[1], SBF_READ_ST);
    check(illegal, 1'b0);
    hold(1, SBF_READ_ST, 7);
    cmd(C_RD, 12'hC00);
    hold(1, SBF_READ_AC, 8);
    check(bank_st[1], SBF_PRECHARGING);
    hold(1, SBF_PRECHARGING, 5);
  endtask

  // main sequence: reset, then each scenario in turn
  initial begin
    arst_n = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    exp_row = 11'h000;
    repeat (6) @(negedge mclk);
    arst_n = 1'b1;
    u_sbf_ctrl_model.gap(2);
    t_mode_load();
    t_activate();
    t_write_ac();
    t_wr_recov();
    t_precharge();
    t_refresh();
    t_power();
    t_full_page();
    t_single_write();
    report_and_stop();
  end

  // watchdog: the run needs a few hundred cycles at most
  initial begin
    #8000;
    n_mismatch++;
    report_and_stop();
  end
endmodule // sbf_bank_fsm_test
`default_nettype wire
